// file: hw/sbba_master.sv
// Behaviour
// - read byte held in data register
// - data register sent on write, captured read
// - index register sent as byte address
// - target address from bits seven to one
// - bit zero selects write or read
// - target write launches access, sets busy
// - short protocol omits the byte address
// - missing acknowledge sets error, write-one clears
// - serial clock 100 kHz, faster in test
`timescale 1ns/1ns
`default_nettype none
module sbba_master (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // configuration register port
  input  wire logic       reg_write_in,
  input  wire logic       reg_read_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  // serial bus pins, open drain
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_out,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out
);
  logic [7:0] byte_data_field;
  logic [7:0] byte_address_field;
  logic [7:0] target_reg;
  logic       short_protocol_select;
  logic       fast_clock_test;
  logic       req_err;
  logic       access_busy_flag;
  sbba_pkg::sbba_state_t state;
  sbba_pkg::sbba_phase_t phase;
  logic [1:0] quarter;
  logic [7:0] tick_cnt;
  logic       tick;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic       scl_drive_low;
  logic       sda_drive_low;
  logic [1:0] sda_sync;
  logic [1:0] scl_sync;
  logic       set_err;
  logic       launch;
  logic       last_phase;
  logic       stretch;
  logic       nack_seen;

  assign launch = reg_write_in && reg_addr_in == sbba_pkg::TARGET_OFFSET && !access_busy_flag;

  // synchronise the pin levels
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sda_sync <= 2'h3;
      scl_sync <= 2'h3;
    end else begin
      sda_sync <= {sda_sync[0], sda_in};
      scl_sync <= {scl_sync[0], scl_in};
    end
  end

  // quarter-period tick, rate chosen by the test bit
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_cnt <= 8'h00;
    end else if (state == sbba_pkg::SBBA_IDLE || tick) begin
      tick_cnt <= 8'h00;
    end else if (!stretch) begin
      tick_cnt <= tick_cnt + 8'h01;
    end
  end
  // high half is timed from when the released clock line is seen high
  assign stretch = !scl_drive_low && !scl_sync[1];
  assign tick = !stretch && (fast_clock_test ? (tick_cnt == 8'(sbba_pkg::QTR_FAST_CYCLES - 1))
                                : (tick_cnt == 8'(sbba_pkg::QTR_CYCLES - 1)));

  // software registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      byte_address_field    <= sbba_pkg::INDEX_RESET;
      target_reg            <= sbba_pkg::TARGET_RESET;
      short_protocol_select <= 1'b0;
      fast_clock_test       <= 1'b0;
    end else if (reg_write_in) begin
      case (reg_addr_in)
        sbba_pkg::INDEX_OFFSET:  byte_address_field <= reg_wdata_in;
        sbba_pkg::TARGET_OFFSET: if (!access_busy_flag) target_reg <= reg_wdata_in;
        sbba_pkg::CTRL_OFFSET: begin
          short_protocol_select <= reg_wdata_in[sbba_pkg::SHORT_PROT_BIT];
          fast_clock_test       <= reg_wdata_in[sbba_pkg::FAST_TEST_BIT];
        end
        default: ;
      endcase
    end
  end

  // data register: software write, or byte captured on a read
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      byte_data_field <= sbba_pkg::DATA_RESET;
    end else if (state == sbba_pkg::SBBA_ACK && phase == sbba_pkg::SBBA_PH_DATA_R
                 && tick && quarter == 2'h0) begin
      byte_data_field <= shift;
    end else if (reg_write_in && reg_addr_in == sbba_pkg::DATA_OFFSET && !access_busy_flag) begin
      byte_data_field <= reg_wdata_in;
    end
  end

  // error flag: hardware set wins over write-one clear
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_err <= 1'b0;
    end else if (set_err) begin
      req_err <= 1'b1;
    end else if (reg_write_in && reg_addr_in == sbba_pkg::CTRL_OFFSET
                 && reg_wdata_in[sbba_pkg::REQ_ERR_BIT]) begin
      req_err <= 1'b0;
    end
  end

  // acknowledge is sampled at the high middle of the ninth clock
  assign set_err = state == sbba_pkg::SBBA_ACK && tick && quarter == 2'h2
                   && phase != sbba_pkg::SBBA_PH_DATA_R && sda_sync[1];
  assign last_phase = (phase == sbba_pkg::SBBA_PH_DATA_W) || (phase == sbba_pkg::SBBA_PH_DATA_R);

  // byte sequencer; each bit spans four quarters: low, low, high, high
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state            <= sbba_pkg::SBBA_IDLE;
      phase            <= sbba_pkg::SBBA_PH_ADDR_W;
      quarter          <= 2'h0;
      bit_cnt          <= 3'h0;
      shift            <= 8'h00;
      access_busy_flag <= 1'b0;
      scl_drive_low    <= 1'b0;
      sda_drive_low    <= 1'b0;
      nack_seen        <= 1'b0;
    end else begin
      case (state)
        sbba_pkg::SBBA_IDLE: begin
          scl_drive_low <= 1'b0;
          sda_drive_low <= 1'b0;
          quarter       <= 2'h0;
          if (launch) begin
            access_busy_flag <= 1'b1;
            state            <= sbba_pkg::SBBA_START;
            nack_seen        <= 1'b0;
            // short protocol sends the address with the direction directly
            if (short_protocol_select && reg_wdata_in[sbba_pkg::DIR_BIT]) begin
              phase <= sbba_pkg::SBBA_PH_ADDR_R;
            end else begin
              phase <= sbba_pkg::SBBA_PH_ADDR_W;
            end
            shift <= {reg_wdata_in[7:1], short_protocol_select & reg_wdata_in[sbba_pkg::DIR_BIT]};
          end
        end
        sbba_pkg::SBBA_START, sbba_pkg::SBBA_RESTART: if (tick) begin
          quarter <= quarter + 2'h1;
          case (quarter)
            2'h0: sda_drive_low <= 1'b0;
            2'h1: scl_drive_low <= 1'b0;
            2'h2: sda_drive_low <= 1'b1; // start condition while clock high
            default: begin
              scl_drive_low <= 1'b1;
              bit_cnt       <= 3'h7;
              state         <= sbba_pkg::SBBA_BYTE;
            end
          endcase
        end
        sbba_pkg::SBBA_BYTE: if (tick) begin
          quarter <= quarter + 2'h1;
          case (quarter)
            2'h0: sda_drive_low <= (phase == sbba_pkg::SBBA_PH_DATA_R) ? 1'b0 : !shift[7];
            2'h1: scl_drive_low <= 1'b0;
            2'h2: if (phase == sbba_pkg::SBBA_PH_DATA_R) shift <= {shift[6:0], sda_sync[1]};
            default: begin
              scl_drive_low <= 1'b1;
              if (phase != sbba_pkg::SBBA_PH_DATA_R) shift <= {shift[6:0], 1'b0};
              bit_cnt <= bit_cnt - 3'h1;
              if (bit_cnt == 3'h0) state <= sbba_pkg::SBBA_ACK;
            end
          endcase
        end
        sbba_pkg::SBBA_ACK: if (tick) begin
          quarter <= quarter + 2'h1;
          case (quarter)
            2'h0: sda_drive_low <= 1'b0; // release; no acknowledge on the read byte
            2'h1: scl_drive_low <= 1'b0;
            2'h2: if (set_err) nack_seen <= 1'b1; // finish the clock low, then stop
            default: begin
              scl_drive_low <= 1'b1;
              bit_cnt       <= 3'h7;
              if (last_phase || nack_seen) begin
                state <= sbba_pkg::SBBA_STOP;
              end else if (phase == sbba_pkg::SBBA_PH_ADDR_R) begin
                phase <= sbba_pkg::SBBA_PH_DATA_R;
                state <= sbba_pkg::SBBA_BYTE;
              end else if (phase == sbba_pkg::SBBA_PH_ADDR_W && short_protocol_select) begin
                phase <= sbba_pkg::SBBA_PH_DATA_W;
                shift <= byte_data_field;
                state <= sbba_pkg::SBBA_BYTE;
              end else if (phase == sbba_pkg::SBBA_PH_ADDR_W) begin
                phase <= sbba_pkg::SBBA_PH_INDEX;
                shift <= byte_address_field;
                state <= sbba_pkg::SBBA_BYTE;
              end else if (!target_reg[sbba_pkg::DIR_BIT]) begin
                phase <= sbba_pkg::SBBA_PH_DATA_W;
                shift <= byte_data_field;
                state <= sbba_pkg::SBBA_BYTE;
              end else begin
                phase <= sbba_pkg::SBBA_PH_ADDR_R;
                shift <= {target_reg[7:1], 1'b1};
                state <= sbba_pkg::SBBA_RESTART;
              end
            end
          endcase
        end
        sbba_pkg::SBBA_STOP: if (tick) begin
          quarter <= quarter + 2'h1;
          case (quarter)
            2'h0: sda_drive_low <= 1'b1;
            2'h1: scl_drive_low <= 1'b0;
            2'h2: sda_drive_low <= 1'b0; // stop condition while clock high
            default: begin
              state            <= sbba_pkg::SBBA_IDLE;
              access_busy_flag <= 1'b0;
            end
          endcase
        end
        default: state <= sbba_pkg::SBBA_IDLE;
      endcase
    end
  end

  // read-back mux
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        sbba_pkg::DATA_OFFSET:   reg_rdata_out <= byte_data_field;
        sbba_pkg::INDEX_OFFSET:  reg_rdata_out <= byte_address_field;
        sbba_pkg::TARGET_OFFSET: reg_rdata_out <= target_reg;
        sbba_pkg::CTRL_OFFSET:   reg_rdata_out <= {short_protocol_select, 1'b0,
                                   access_busy_flag, 2'b00, fast_clock_test, req_err, 1'b0};
        default:                 reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // open-drain pins: drive low only
  assign scl_out    = 1'b0;
  assign sda_out    = 1'b0;
  assign scl_oe_out = scl_drive_low;
  assign sda_oe_out = sda_drive_low;
endmodule
`default_nettype wire

// file: hw/sbba_pkg.sv
package sbba_pkg;
  // register byte offsets in configuration space
  localparam logic [7:0] DATA_OFFSET   = 8'hb0;
  localparam logic [7:0] INDEX_OFFSET  = 8'hb1;
  localparam logic [7:0] TARGET_OFFSET = 8'hb2;
  localparam logic [7:0] CTRL_OFFSET   = 8'hb3;
  // control, status and target direction field positions
  localparam int SHORT_PROT_BIT = 7;
  localparam int BUSY_BIT       = 5;
  localparam int FAST_TEST_BIT  = 2;
  localparam int REQ_ERR_BIT    = 1;
  localparam int DIR_BIT        = 0;
  // reset values
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam logic [7:0] INDEX_RESET  = 8'h00;
  localparam logic [7:0] TARGET_RESET = 8'h00;
  // timing
  localparam int CLK_HZ       = 20000000;
  localparam int SCL_HZ       = 100000;
  localparam int SCL_FAST_HZ  = 400000;
  // quarter period of the serial clock in host clock cycles (rounded down, at least 1)
  localparam int QTR_CYCLES      = (CLK_HZ / (4 * SCL_HZ)) < 1 ? 1 : CLK_HZ / (4 * SCL_HZ);
  localparam int QTR_FAST_CYCLES = (CLK_HZ / (4 * SCL_FAST_HZ)) < 1 ? 1
                                   : CLK_HZ / (4 * SCL_FAST_HZ);
  typedef enum logic [3:0] {
    SBBA_IDLE, SBBA_START, SBBA_BYTE, SBBA_ACK, SBBA_RESTART, SBBA_STOP
  } sbba_state_t;
  // byte phases of one access
  typedef enum logic [2:0] {
    SBBA_PH_ADDR_W, SBBA_PH_INDEX, SBBA_PH_DATA_W, SBBA_PH_ADDR_R, SBBA_PH_DATA_R
  } sbba_phase_t;
endpackage

// file: testbench/sbba_master_checker.sv
`timescale 1ns/1ns
`default_nettype none
module sbba_master_checker (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       reset_n_in,
  // register port
  input wire logic       reg_write_in,
  input wire logic       reg_read_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // serial pins
  input wire logic       scl_out,
  input wire logic       scl_oe_out,
  input wire logic       sda_out,
  input wire logic       sda_oe_out
);
  logic [8:0] quiet;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // counts cycles with both pins released; 256 of them means no access runs
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) quiet <= 9'h000;
    else if (scl_oe_out || sda_oe_out) quiet <= 9'h000;
    else if (!quiet[8]) quiet <= quiet + 9'h001;
  end
  AST_PINS_LOW: assert property (!scl_out && !sda_out)
    else $error("pin data not low");
  AST_LAUNCH: assert property (
    quiet[8] && reg_write_in && reg_addr_in == 8'hb2 |-> ##[1:160] sda_oe_out && !scl_oe_out)
    else $error("no start after launch");
  AST_BUSY: assert property (
    quiet[8] && reg_write_in && reg_addr_in == 8'hb2 ##2 reg_read_in && reg_addr_in == 8'hb3
    |=> reg_rdata_out[5]) else $error("busy not set");
  AST_DATA_RB: assert property (
    quiet[8] && reg_write_in && reg_addr_in == 8'hb0 ##2 reg_read_in && reg_addr_in == 8'hb0
    |=> reg_rdata_out == $past(reg_wdata_in, 3)) else $error("data readback wrong");
  AST_ERR_CLR: assert property (
    quiet[8] && reg_write_in && reg_addr_in == 8'hb3 && reg_wdata_in[1]
    ##2 reg_read_in && reg_addr_in == 8'hb3 |=> !reg_rdata_out[1]) else $error("error not cleared");
  AST_UNMAPPED: assert property (
    reg_read_in && reg_addr_in[7:2] != 6'h2c |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  AST_SCL_LOW: assert property ($rose(scl_oe_out) |-> ##[10:210] !scl_oe_out)
    else $error("clock low phase out of range");
  AST_RDATA_HOLD: assert property (!reg_read_in |=> $stable(reg_rdata_out))
    else $error("read data changed");
  // main scenarios reached
  cover property (reg_write_in && reg_addr_in == 8'hb2 && reg_wdata_in[0]);
  cover property (reg_read_in && reg_addr_in == 8'hb3 ##1 reg_rdata_out[1]);
  cover property (quiet[8] && $rose(sda_oe_out));
endmodule
bind sbba_master sbba_master_checker sbba_master_checker_inst (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out));
`default_nettype wire

// file: testbench/sbba_target_model.sv
`timescale 1ns/1ns
`default_nettype none
module sbba_target_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  // wire levels
  input  wire logic scl_in,
  input  wire logic sda_in,
  // high pulls data low
  output logic      sda_oe_out
);
  logic [7:0] mem [0:255];
  logic [7:0] sh, ptr;
  logic       act, first, rd, hit, ack, np;
  int         n;
  initial begin
    {sda_oe_out, act, first, rd, hit, ack, np, ptr, sh, n} = '0;
    for (int k = 0; k < 256; k++) mem[k] = 8'(k) ^ 8'ha5;
  end
  // start or repeated start, then stop
  always @(negedge sda_in) if (scl_in) {act, first, rd, n} = {3'b110, 32'd0};
  always @(posedge sda_in) if (scl_in) {act, sda_oe_out} = 2'b00;
  // bits in MSB first; address, then pointer, then stored bytes
  always @(posedge scl_in) if (act) begin
    if (n == 8 && rd && !first && sda_in) act = 1'b0; // no acknowledge: let go of the line
    if (n < 8) sh = {sh[6:0], sda_in};
    n = (n == 8) ? 0 : n + 1;
    if (n == 8) begin
      ack = (first ? sh[7:1] == ADDR : hit) && (first || !rd);
      if (first) {hit, rd, np, first} = {sh[7:1] == ADDR, sh[0], !sh[0], 1'b0};
      else if (rd) ptr++;
      else if (np) {ptr, np} = {sh, 1'b0};
      else begin
        mem[ptr] = sh;
        ptr++;
      end
    end
  end
  // acknowledge slot, or read byte bits, after the falling clock
  always @(negedge scl_in) if (act)
    sda_oe_out = hit && ((n == 8 && ack) || (rd && !first && n < 8 && !mem[ptr][7 - n]));
endmodule
`default_nettype wire

// file: testbench/sbba_master_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define check_eq(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module sbba_master_tb;
  localparam logic [6:0] TGT = 7'h50;
  logic        clk_in, reset_n_in, reg_write_in, reg_read_in, busy, rd_seen;
  logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, d, i, shadow [0:255];
  logic        scl_oe, sda_oe, tgt_oe;
  logic [15:0] seed, nt, notes [$];
  int          fail_count, checks;
  wire logic   scl = !scl_oe;
  wire logic   sda = !(sda_oe || tgt_oe);
  sbba_master sbba_master_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .scl_in(scl), .scl_out(),
    .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe));
  sbba_target_model #(.ADDR(TGT)) sbba_target_model_inst (.scl_in(scl), .sda_in(sda),
    .sda_oe_out(tgt_oe));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    notes.push_back({m, e & m});
    @(posedge clk_in);
    reg_read_in <= 1'b0;
    @(posedge clk_in);
  endtask
  // launch, overwrite data while busy, poll busy, let the bus settle
  task automatic access(input logic [7:0] a);
    wr(8'hb2, a);
    busy = 1'b1;
    for (int k = 0; busy; k++) begin
      rd(8'hb3, 8'h20, k == 0 ? 8'h20 : 8'h00);
      busy = reg_rdata_out[5] !== 1'b0;
      if (k == 0) wr(8'hb0, 8'h5a);
    end
    repeat (260) @(posedge clk_in);
  endtask
  task automatic complete_run;
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // each read answer against the oldest note
  always @(posedge clk_in) begin
    if (rd_seen && notes.size() > 0) begin
      nt = notes.pop_front();
      `check_eq("reg_rdata_out", nt[7:0], reg_rdata_out & nt[15:8])
    end
    rd_seen <= reg_read_in;
  end
  initial begin
    repeat (40000) @(posedge clk_in);
    fail_count++;
    complete_run();
  end
  initial begin
    {reset_n_in, reg_write_in, reg_read_in, reg_addr_in, reg_wdata_in} = '0;
    seed = 16'he23e;
    for (int k = 0; k < 256; k++) shadow[k] = 8'(k) ^ 8'ha5;
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (260) @(posedge clk_in);
    for (int k = 0; k < 5; k++) rd(8'hb0 + 8'(k), 8'h00, 8'hff);
    wr(8'hb0, 8'h3c);
    rd(8'hb0, 8'h3c, 8'hff);
    wr(8'hb3, 8'h04);
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      {i, d} = seed;
      shadow[i] = d;
      wr(8'hb0, d);
      wr(8'hb1, i);
      rd(8'hb1, i, 8'hff);
      access({TGT, 1'b0});
      rd(8'hb3, 8'h00, 8'h02);
      access({TGT, 1'b1});
      rd(8'hb0, d, 8'hff);
      rd(8'hb2, {TGT, 1'b1}, 8'hff);
    end
    access({TGT ^ 7'h01, 1'b0});
    rd(8'hb3, 8'h02, 8'h02);
    wr(8'hb3, 8'h06);
    rd(8'hb3, 8'h04, 8'h86);
    wr(8'hb3, 8'h84);
    wr(8'hb0, 8'h17);
    access({TGT, 1'b0});
    access({TGT, 1'b1});
    rd(8'hb0, shadow[8'h17], 8'hff);
    wr(8'hb3, 8'h00);
    wr(8'hb1, i);
    access({TGT, 1'b1});
    rd(8'hb0, shadow[i], 8'hff);
    @(posedge clk_in);
    complete_run();
  end
endmodule
`default_nettype wire
